//--- fcpf_pkg.sv
// Package for the full-closed position feedback block
// Assumes a 100 MHz single clock and an AXI4-Lite register port
`default_nettype none
package fcpf_pkg;
   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_NUMER = 8'h04;
   localparam logic [7:0] OFS_SHIFT = 8'h08;
   localparam logic [7:0] OFS_DENOM = 8'h0C;
   localparam logic [7:0] OFS_LIMIT = 8'h10;
   localparam logic [7:0] OFS_CMDMUL = 8'h14;
   localparam logic [7:0] OFS_CMDDIV = 8'h18;
   localparam logic [7:0] OFS_STATUS = 8'h1C;
   localparam logic [7:0] OFS_MASK = 8'h20;
   localparam logic [7:0] OFS_DEV = 8'h24;
   localparam logic [7:0] OFS_ADC = 8'h28;
   localparam logic [7:0] OFS_MON = 8'h2C;
   localparam logic [7:0] OFS_COMMIT = 8'h30;
   // ---------------------------------------------------------------
   // Fields and reset values
   // ---------------------------------------------------------------
   localparam int CTRL_INVERT = 0;
   localparam int CTRL_CLEAR = 1;
   localparam int ST_FAULT = 0;
   localparam int ST_CMDERR = 1;
   localparam int LIMIT_UNIT_SHIFT = 4;
   localparam int MON_SCALE_SEL_6V = 3;
   localparam int MON_RPM_FULL = 3000;
   localparam int MON_MV_FULL = 6000;
   localparam int MON_MV_SPAN = 10000;
   localparam logic [15:0] RST_NUMER = 16'h0001;
   localparam logic [4:0] RST_SHIFT = 5'h00;
   localparam logic [15:0] RST_DENOM = 16'h0001;
   localparam logic [15:0] RST_LIMIT = 16'h0010;
   localparam int CMD_WIDTH = 16;
   localparam int LIM_WIDTH = 10;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int CLK_MHZ = 100;
   localparam int ZPULSE_NS = 1000;
   localparam int ZPULSE_CYC = (ZPULSE_NS * CLK_MHZ) / 1000;
endpackage : fcpf_pkg
`default_nettype wire

//--- fcpf_scale_if.sv
// Carrier between the top and the ratio scaler
// Assumes both ends sit on the same clock
`timescale 1ns/1ps
`default_nettype none
interface fcpf_scale_if;
   logic step;
   logic dir;
   logic [15:0] numer;
   logic [4:0] shift;
   logic [15:0] denom;
   logic out_step;
   logic out_dir;
   modport master (output step, dir, numer, shift, denom,
                   input out_step, out_dir);
   modport slave (input step, dir, numer, shift, denom,
                  output out_step, out_dir);
endinterface : fcpf_scale_if
`default_nettype wire

//--- fcpf_scaler.sv
// Rational step scaler: out rate = in rate * numer * 2^shift / denom
// Assumes one step in per cycle at most; accumulator emits at most one
// output step per cycle, so ratios above one saturate at clock rate
`timescale 1ns/1ps
`default_nettype none
module fcpf_scaler (
   input wire logic CLOCK,
   input wire logic RSTN,
   fcpf_scale_if.slave s
);
   logic [47:0] acc;
   logic [47:0] gain;
   logic [47:0] den;
   logic [47:0] sum;
   assign gain = 48'(s.numer) << s.shift;
   assign den = 48'(s.denom == 16'h0000 ? 16'h0001 : s.denom);
   assign sum = acc + (s.step ? gain : 48'h0);
   // ---------------------------------------------------------------
   // Accumulate and emit
   // ---------------------------------------------------------------
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         acc <= 48'h0;
         s.out_step <= 1'b0;
         s.out_dir <= 1'b0;
      end else begin
         if (s.step) begin
            s.out_dir <= s.dir;
         end
         if (sum >= den) begin
            acc <= sum - den;
            s.out_step <= 1'b1;
         end else begin
            acc <= sum;
            s.out_step <= 1'b0;
         end
      end
   end
endmodule : fcpf_scaler
`default_nettype wire

//--- fcpf_top.sv
// Full-closed position feedback: scale feedback, hybrid deviation, fault
// Function
// R1 - Scale feedback by numerator times 2^shift over denominator
// R2 - Invert setting reverses scale count sign
// R3 - Hybrid deviation is encoder minus scale position
// R4 - Excess limit counts in 16 scale pulses
// R5 - Deviation beyond limit raises hybrid excess fault
// R6 - Command pulses scaled into scale units
// R7 - Host differential pulses at most 500 kpps
// R8 - Host open collector pulses at most 200 kpps
// R9 - Host line-driver-only input at most 2 Mpps
// R10 - Command converter word is 16-bit signed
// R11 - Limit converters are 10-bit unsigned
// R12 - Divided A, B, Z out as pairs
// R13 - Z also narrow open collector pulse
// R14 - Scale setup applies only after commit
// R15 - Monitor select 3 gives 6V per 3000 rpm
// R16 - User keeps ratio between 1/20 and 20
// R17 - Power-on parameters take effect at commit
// R18 - Compare every cycle, fault latched until reset
// Assumes encoder and scale quadrature already decoded to step/dir pins
`timescale 1ns/1ps
`default_nettype none
module fcpf_top #(
   parameter int POS_WIDTH = 32
) (
   input wire logic CLOCK,
   input wire logic RSTN,
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic ENC_STEP,
   input wire logic ENC_DIR,
   input wire logic SCALE_STEP,
   input wire logic SCALE_DIR,
   input wire logic CMD_STEP,
   input wire logic CMD_DIR,
   input wire logic [15:0] CMD_CONV,
   input wire logic [9:0] CCW_LIMIT_CONV,
   input wire logic [9:0] CW_LIMIT_CONV,
   output logic [15:0] SPEED_MON,
   output logic DIV_A_P,
   output logic DIV_A_N,
   output logic DIV_B_P,
   output logic DIV_B_N,
   output logic DIV_Z_P,
   output logic DIV_Z_N,
   output logic Z_OC_OUT,
   output logic Z_OC_OE,
   output logic CMD_SCALED_STEP,
   output logic CMD_SCALED_DIR,
   output logic HYBRID_EXCESS_FAULT,
   output logic IRQ
);
   default clocking chk_clk @(posedge CLOCK);
   endclocking
   default disable iff (!RSTN);
   // Narrow counters would wrap into false faults on long travel
   if (POS_WIDTH < 24 || POS_WIDTH > 32) begin : g_bad_width
      $error("POS_WIDTH must be 24 to 32");
   end
   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   logic [5:0] sync1;
   logic [5:0] sync2;
   logic [5:0] sync3;
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         sync1 <= 6'h00;
         sync2 <= 6'h00;
         sync3 <= 6'h00;
      end else begin
         sync1 <= {ENC_STEP, ENC_DIR, SCALE_STEP, SCALE_DIR,
                   CMD_STEP, CMD_DIR};
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end
   logic enc_step;
   logic scale_step;
   logic cmd_step;
   assign enc_step = sync2[5] & ~sync3[5];
   assign scale_step = sync2[3] & ~sync3[3];
   assign cmd_step = sync2[1] & ~sync3[1];
   // ---------------------------------------------------------------
   // Registers: staged and active copies
   // ---------------------------------------------------------------
   logic [15:0] numer;
   logic [4:0] shift;
   logic [15:0] denom;
   logic [15:0] limit;
   logic invert;
   logic [15:0] cmd_mul;
   logic [15:0] cmd_div;
   logic [1:0] mon_sel;
   logic [15:0] a_numer;
   logic [4:0] a_shift;
   logic [15:0] a_denom;
   logic a_invert;
   logic [1:0] status;
   logic [1:0] mask;
   logic [POS_WIDTH-1:0] enc_pos;
   logic [POS_WIDTH-1:0] scale_pos;
   logic [POS_WIDTH-1:0] deviation;
   logic fault;
   logic commit_pulse;
   logic clear_pulse;
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic do_write;
   logic wr_ok;
   assign S_AXI_AWREADY = ~aw_held & ~S_AXI_BVALID;
   assign S_AXI_WREADY = ~w_held & ~S_AXI_BVALID;
   assign do_write = aw_held & w_held & ~S_AXI_BVALID;
   always_comb begin
      case (aw_addr)
         fcpf_pkg::OFS_CTRL, fcpf_pkg::OFS_NUMER, fcpf_pkg::OFS_SHIFT,
         fcpf_pkg::OFS_DENOM, fcpf_pkg::OFS_LIMIT, fcpf_pkg::OFS_CMDMUL,
         fcpf_pkg::OFS_CMDDIV, fcpf_pkg::OFS_MASK, fcpf_pkg::OFS_MON,
         fcpf_pkg::OFS_COMMIT: wr_ok = 1'b1;
         default: wr_ok = 1'b0;
      endcase
   end
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0;
         w_strb <= 4'h0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= fcpf_pkg::RESP_OKAY;
      end else begin
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_held <= 1'b1;
            aw_addr <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_held <= 1'b1;
            w_data <= S_AXI_WDATA;
            w_strb <= S_AXI_WSTRB;
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= wr_ok ? fcpf_pkg::RESP_OKAY
                                 : fcpf_pkg::RESP_SLVERR;
         end else if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
         end
      end
   end
   assign commit_pulse = do_write && aw_addr == fcpf_pkg::OFS_COMMIT
                         && w_strb[0] && w_data[0];
   assign clear_pulse = do_write && aw_addr == fcpf_pkg::OFS_CTRL
                        && w_strb[0] && w_data[fcpf_pkg::CTRL_CLEAR];
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         numer <= fcpf_pkg::RST_NUMER;
         shift <= fcpf_pkg::RST_SHIFT;
         denom <= fcpf_pkg::RST_DENOM;
         limit <= fcpf_pkg::RST_LIMIT;
         invert <= 1'b0;
         cmd_mul <= fcpf_pkg::RST_NUMER;
         cmd_div <= fcpf_pkg::RST_DENOM;
         mask <= 2'h0;
         mon_sel <= 2'(fcpf_pkg::MON_SCALE_SEL_6V);
      end else if (do_write && w_strb[0]) begin
         case (aw_addr)
            fcpf_pkg::OFS_CTRL: invert <= w_data[fcpf_pkg::CTRL_INVERT];
            fcpf_pkg::OFS_NUMER: numer <= w_data[15:0];
            fcpf_pkg::OFS_SHIFT: shift <= w_data[4:0];
            fcpf_pkg::OFS_DENOM: denom <= w_data[15:0];
            fcpf_pkg::OFS_LIMIT: limit <= w_data[15:0];
            fcpf_pkg::OFS_CMDMUL: cmd_mul <= w_data[15:0];
            fcpf_pkg::OFS_CMDDIV: cmd_div <= w_data[15:0];
            fcpf_pkg::OFS_MASK: mask <= w_data[1:0];
            fcpf_pkg::OFS_MON: mon_sel <= w_data[1:0];
            default: ;
         endcase
      end
   end
   // Scale setup is held in staged copies until a commit, so a half
   // written ratio never reaches the running loop
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         a_numer <= fcpf_pkg::RST_NUMER;
         a_shift <= fcpf_pkg::RST_SHIFT;
         a_denom <= fcpf_pkg::RST_DENOM;
         a_invert <= 1'b0;
      end else if (commit_pulse) begin // R14 R17
         a_numer <= numer;
         a_shift <= shift;
         a_denom <= denom;
         a_invert <= invert;
      end
   end
   // ---------------------------------------------------------------
   // Read channel
   // ---------------------------------------------------------------
   logic [31:0] next_rdata;
   logic rd_ok;
   logic rd_status;
   logic [15:0] speed;
   assign S_AXI_ARREADY = ~S_AXI_RVALID;
   assign rd_status = S_AXI_ARVALID && S_AXI_ARREADY
                      && S_AXI_ARADDR == fcpf_pkg::OFS_STATUS;
   always_comb begin
      next_rdata = 32'h0;
      rd_ok = 1'b1;
      case (S_AXI_ARADDR)
         fcpf_pkg::OFS_CTRL: next_rdata = {31'h0, invert};
         fcpf_pkg::OFS_NUMER: next_rdata = {16'h0, numer};
         fcpf_pkg::OFS_SHIFT: next_rdata = {27'h0, shift};
         fcpf_pkg::OFS_DENOM: next_rdata = {16'h0, denom};
         fcpf_pkg::OFS_LIMIT: next_rdata = {16'h0, limit};
         fcpf_pkg::OFS_CMDMUL: next_rdata = {16'h0, cmd_mul};
         fcpf_pkg::OFS_CMDDIV: next_rdata = {16'h0, cmd_div};
         fcpf_pkg::OFS_STATUS: next_rdata = {30'h0, status};
         fcpf_pkg::OFS_MASK: next_rdata = {30'h0, mask};
         fcpf_pkg::OFS_DEV: next_rdata = 32'(signed'(deviation));
         fcpf_pkg::OFS_ADC: next_rdata = {CMD_CONV, 6'h00,
                                          CCW_LIMIT_CONV}; // R10 R11
         fcpf_pkg::OFS_MON: next_rdata = {4'h0, CW_LIMIT_CONV,
                                          mon_sel, speed}; // R11 R15
         fcpf_pkg::OFS_COMMIT: next_rdata = 32'h0;
         default: rd_ok = 1'b0;
      endcase
   end
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h0;
         S_AXI_RRESP <= fcpf_pkg::RESP_OKAY;
      end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         S_AXI_RVALID <= 1'b1;
         S_AXI_RDATA <= next_rdata;
         S_AXI_RRESP <= rd_ok ? fcpf_pkg::RESP_OKAY
                              : fcpf_pkg::RESP_SLVERR;
      end else if (S_AXI_RREADY) begin
         S_AXI_RVALID <= 1'b0;
      end
   end
   // ---------------------------------------------------------------
   // Feedback scaling and hybrid deviation
   // ---------------------------------------------------------------
   fcpf_scale_if fb_if ();
   fcpf_scale_if cmd_if ();
   assign fb_if.step = scale_step;
   assign fb_if.dir = sync2[2] ^ a_invert; // R2
   assign fb_if.numer = a_numer; // R1
   assign fb_if.shift = a_shift;
   assign fb_if.denom = a_denom;
   assign cmd_if.step = cmd_step;
   assign cmd_if.dir = sync2[0];
   assign cmd_if.numer = cmd_mul; // R6
   assign cmd_if.shift = 5'h00;
   assign cmd_if.denom = cmd_div;
   fcpf_scaler u_fb (.CLOCK(CLOCK), .RSTN(RSTN), .s(fb_if.slave));
   fcpf_scaler u_cmd (.CLOCK(CLOCK), .RSTN(RSTN), .s(cmd_if.slave));
   assign CMD_SCALED_STEP = cmd_if.out_step;
   assign CMD_SCALED_DIR = cmd_if.out_dir;
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         enc_pos <= '0;
         scale_pos <= '0;
      end else begin
         if (enc_step) begin
            enc_pos <= sync2[4] ? enc_pos - 1'b1 : enc_pos + 1'b1;
         end
         if (fb_if.out_step) begin
            scale_pos <= fb_if.out_dir ? scale_pos - 1'b1
                                       : scale_pos + 1'b1;
         end
      end
   end
   assign deviation = enc_pos - scale_pos; // R3
   logic [POS_WIDTH-1:0] dev_mag;
   logic [POS_WIDTH-1:0] lim_pulses;
   logic over;
   assign dev_mag = deviation[POS_WIDTH-1] ? -deviation : deviation;
   assign lim_pulses = POS_WIDTH'(limit) << fcpf_pkg::LIMIT_UNIT_SHIFT; // R4
   assign over = dev_mag > lim_pulses;
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         fault <= 1'b0;
      end else if (over) begin // R5 R18
         fault <= 1'b1;
      end
   end
   assign HYBRID_EXCESS_FAULT = fault;
   // ---------------------------------------------------------------
   // Sticky status: fault event, bad command divisor
   // ---------------------------------------------------------------
   logic [1:0] events;
   assign events = {cmd_div == 16'h0000, over};
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         status <= 2'h0;
      end else begin
         // A new event in the reading cycle survives the clear
         status <= (rd_status ? 2'h0 : status) | events;
      end
   end
   assign IRQ = |(status & mask);
   // ---------------------------------------------------------------
   // Divided encoder outputs and narrow Z pulse
   // ---------------------------------------------------------------
   logic [1:0] quad;
   logic [POS_WIDTH-1:0] z_cnt;
   logic [$clog2(fcpf_pkg::ZPULSE_CYC+1)-1:0] z_width;
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         quad <= 2'h0;
         z_width <= '0;
         z_cnt <= '0;
      end else begin
         if (enc_step) begin
            quad <= sync2[4] ? quad - 2'h1 : quad + 2'h1;
            z_cnt <= z_cnt + 1'b1;
            if (z_cnt[11:0] == 12'hFFF) begin
               z_width <= ($bits(z_width))'(fcpf_pkg::ZPULSE_CYC);
            end
         end
         if (z_width != '0) begin
            z_width <= z_width - 1'b1;
         end
      end
   end
   assign DIV_A_P = quad[1]; // R12
   assign DIV_A_N = ~quad[1];
   assign DIV_B_P = quad[1] ^ quad[0];
   assign DIV_B_N = ~(quad[1] ^ quad[0]);
   assign DIV_Z_P = z_width != '0;
   assign DIV_Z_N = z_width == '0;
   assign Z_OC_OUT = 1'b0; // R13
   assign Z_OC_OE = z_width != '0;
   // ---------------------------------------------------------------
   // Speed monitor: counts per millisecond into millivolt code
   // ---------------------------------------------------------------
   logic [16:0] ms_cnt;
   logic [15:0] win_cnt;
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         ms_cnt <= 17'h0;
         win_cnt <= 16'h0;
         speed <= 16'h0;
      end else if (ms_cnt == 17'(fcpf_pkg::CLK_MHZ * 1000 - 1)) begin
         ms_cnt <= 17'h0;
         win_cnt <= 16'h0;
         // Full scale 6000 mV at 3000 steps per window when select is 3
         speed <= (mon_sel == 2'(fcpf_pkg::MON_SCALE_SEL_6V))
                  ? 16'(32'(win_cnt) * fcpf_pkg::MON_MV_FULL
                        / fcpf_pkg::MON_RPM_FULL) // R15
                  : 16'(32'(win_cnt) * fcpf_pkg::MON_MV_SPAN
                        / fcpf_pkg::MON_RPM_FULL);
      end else begin
         ms_cnt <= ms_cnt + 17'h1;
         if (enc_step) begin
            win_cnt <= win_cnt + 16'h1;
         end
      end
   end
   assign SPEED_MON = speed;
   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   AST_FAULT_SET: assert property (over |=> HYBRID_EXCESS_FAULT) // R5
      else $error("fault not raised");
   AST_FAULT_HOLD: assert property (HYBRID_EXCESS_FAULT |=> // R18
      HYBRID_EXCESS_FAULT) else $error("fault dropped");
   AST_NO_SPURIOUS: assert property (!HYBRID_EXCESS_FAULT && !over // R5
      |=> !HYBRID_EXCESS_FAULT) else $error("fault without cause");
   AST_DEV: assert property ($changed(enc_pos) && !$changed(scale_pos) // R3
      |-> deviation == POS_WIDTH'($past(deviation)
                                  + (sync3[4] ? '1 : 1)))
      else $error("deviation wrong");
   AST_LIMIT_UNIT: assert property (over == (33'(dev_mag) > // R4
      33'(limit) * 33'd16)) else $error("limit unit wrong");
   AST_COMMIT: assert property (!commit_pulse |=> $stable(a_numer) // R14
      && $stable(a_denom) && $stable(a_invert))
      else $error("setup applied early");
   AST_INVERT: assert property (scale_step |=> fb_if.out_dir == // R2
      ($past(sync2[2]) ^ $past(a_invert))) else $error("invert wrong");
   AST_UNITY: assert property (a_numer == 16'h0001 && a_shift == 5'h00 // R1
      && a_denom == 16'h0001 && $past(a_denom) == 16'h0001 && scale_step
      |=> fb_if.out_step) else $error("unity ratio lost a step");
   AST_ZOC: assert property ($rose(Z_OC_OE) |-> // R13
      (DIV_Z_P && !DIV_Z_N && !Z_OC_OUT) [*8])
      else $error("Z pair mismatch");
   COV_FAULT: cover property ($rose(HYBRID_EXCESS_FAULT));
   COV_COMMIT: cover property (commit_pulse);
   COV_IRQ: cover property ($rose(IRQ));
   COV_ZPULSE: cover property ($rose(Z_OC_OE));
endmodule : fcpf_top
`default_nettype wire

//--- fcpf_feedback_model.sv
// Far side: host pulse source plus encoder and scale step sources
// Assumes one caller at a time; index 0 encoder, 1 scale, 2 host command
`timescale 1ns/1ps
`default_nettype none
module fcpf_feedback_model (
   input wire logic CLOCK,
   output logic [2:0] step,
   output logic [2:0] dir
);
   initial begin
      step = 3'h0;
      dir = 3'h0;
   end
   // ---------------------------------------------------------------
   // Pulse train, direction set one cycle ahead of the first edge
   // ---------------------------------------------------------------
   task automatic move(input int sel, input int n, input logic dn,
                       input int per);
      int p;
      p = per;
      // Host pulse period kept at or above the slowest input's limit
      if (sel == 2 && p < 500) p = 500;
      dir[sel] <= dn;
      @(posedge CLOCK);
      for (int i = 0; i < n; i++) begin
         step[sel] <= 1'b1;
         repeat (p / 2) @(posedge CLOCK);
         step[sel] <= 1'b0;
         repeat (p - p / 2) @(posedge CLOCK);
      end
   endtask : move
endmodule : fcpf_feedback_model
`default_nettype wire

//--- test_full_closed_position_feedback.sv
// Self-checking bench for the full-closed position feedback block
// Assumes the far-side model drives all step/dir pins
`timescale 1ns/1ps
`default_nettype none
module test_full_closed_position_feedback;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic [15:0] cmd_conv = 16'h0;
   logic [9:0] ccw = 10'h0;
   logic [9:0] cw = 10'h0;
   logic awready, wready, bvalid, arready, rvalid, cstep, fault, irq;
   logic zp, zoc, zoe;
   logic [1:0] bresp, rresp, resp;
   logic [31:0] rdata, rd;
   logic [2:0] stp, dir;
   int err_total = 0;
   int total_checks = 0;
   int cmd_cnt = 0;
   int n;
   always #5 clock = ~clock;
   always @(posedge clock) if (cstep === 1'b1) cmd_cnt++;
   fcpf_feedback_model fcpf_feedback_model_i (.CLOCK(clock), .step(stp),
      .dir(dir));
   fcpf_top fcpf_top_i (.CLOCK(clock), .RSTN(rstn),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
      .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .ENC_STEP(stp[0]), .ENC_DIR(dir[0]), .SCALE_STEP(stp[1]),
      .SCALE_DIR(dir[1]), .CMD_STEP(stp[2]), .CMD_DIR(dir[2]),
      .CMD_CONV(cmd_conv), .CCW_LIMIT_CONV(ccw), .CW_LIMIT_CONV(cw),
      .SPEED_MON(), .DIV_A_P(), .DIV_A_N(), .DIV_B_P(), .DIV_B_N(),
      .DIV_Z_P(zp), .DIV_Z_N(), .Z_OC_OUT(zoc), .Z_OC_OE(zoe),
      .CMD_SCALED_STEP(cstep), .CMD_SCALED_DIR(),
      .HYBRID_EXCESS_FAULT(fault), .IRQ(irq));
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic int sc(input int c, input int nu, input int sh,
                             input int de);
      return c * nu * (1 << sh) / de;
   endfunction : sc
   task automatic chk(input string nm, input logic [31:0] s,
                      input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic do_reset;
      rstn <= 1'b0;
      repeat (4) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
   endtask : do_reset
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clock);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      resp = bresp;
      bready <= 1'b0;
      @(posedge clock);
   endtask : axw
   task automatic axr(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clock);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rd = rdata;
      resp = rresp;
      rready <= 1'b0;
      @(posedge clock);
   endtask : axr
   task automatic mv(input int sel, input int k, input logic dn);
      fcpf_feedback_model_i.move(sel, k, dn, 4);
      // The last scale count registers on the edge the move returns at; encoder counts register one edge earlier
      @(posedge clock);
   endtask : mv
   task automatic print_verdict;
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : print_verdict
   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      void'($urandom(32'h67e76562));
      do_reset;
      cmd_conv <= 16'($urandom);
      ccw <= 10'($urandom);
      cw <= 10'($urandom);
      axr(fcpf_pkg::OFS_NUMER);
      chk("numer", rd, 32'(fcpf_pkg::RST_NUMER));
      axr(fcpf_pkg::OFS_SHIFT);
      chk("shift", rd, 32'(fcpf_pkg::RST_SHIFT));
      axr(fcpf_pkg::OFS_DENOM);
      chk("denom", rd, 32'(fcpf_pkg::RST_DENOM));
      axr(fcpf_pkg::OFS_LIMIT);
      chk("limit", rd, 32'(fcpf_pkg::RST_LIMIT));
      axr(8'h40);
      chk("unmapped", 32'(resp), 32'(fcpf_pkg::RESP_SLVERR));
      axr(fcpf_pkg::OFS_ADC);
      chk("adc", rd, {cmd_conv, 6'h00, ccw});
      axr(fcpf_pkg::OFS_MON);
      chk("mon", rd,
          {4'h0, cw, 2'(fcpf_pkg::MON_SCALE_SEL_6V), 16'h0});
      $display("test registers done");
      n = 1 + $urandom % 10;
      mv(0, n, 1'b0);
      // Ratio 1/2 stays inside the recommended span
      axw(fcpf_pkg::OFS_DENOM, 32'h2);
      mv(1, 8, 1'b0);
      axr(fcpf_pkg::OFS_DEV);
      chk("dev", rd, 32'(n - 8));
      axw(fcpf_pkg::OFS_COMMIT, 32'h1);
      mv(1, 8, 1'b0);
      axr(fcpf_pkg::OFS_DEV);
      chk("dev", rd, 32'(n - 8 - sc(8, 1, 0, 2)));
      axw(fcpf_pkg::OFS_CTRL, 32'h1);
      axw(fcpf_pkg::OFS_COMMIT, 32'h1);
      mv(1, 4, 1'b0);
      axr(fcpf_pkg::OFS_DEV);
      chk("dev", rd, 32'(n - 12 + sc(4, 1, 0, 2)));
      $display("test deviation done");
      axw(fcpf_pkg::OFS_CMDMUL, 32'h1);
      axw(fcpf_pkg::OFS_CMDDIV, 32'h2);
      cmd_cnt = 0;
      fcpf_feedback_model_i.move(2, 8, 1'b0, 500);
      chk("cmd", 32'(cmd_cnt), 32'(sc(8, 1, 0, 2)));
      $display("test command done");
      do_reset;
      axw(fcpf_pkg::OFS_LIMIT, 32'h1);
      axw(fcpf_pkg::OFS_MASK, 32'h1);
      mv(0, 16, 1'b0);
      chk("fault", 32'(fault), 32'h0);
      chk("irq", 32'(irq), 32'h0);
      mv(0, 1, 1'b0);
      chk("fault", 32'(fault), 32'h1);
      mv(0, 17, 1'b1);
      chk("fault", 32'(fault), 32'h1);
      chk("irq", 32'(irq), 32'h1);
      axr(fcpf_pkg::OFS_STATUS);
      chk("status", 32'(rd[0]), 32'h1);
      chk("irq", 32'(irq), 32'h0);
      $display("test fault done");
      // Z marks every 4096th encoder count; 34 counted since reset
      mv(0, 4096 - 34, 1'b0);
      chk("z pair", 32'(zp), 32'h1);
      chk("z oc", {30'h0, zoe, zoc}, 32'h2);
      $display("test z pulse done");
      print_verdict;
   end
   initial begin
      repeat (50000) @(posedge clock);
      err_total++;
      $display("ERROR watchdog expected done seen hang");
      print_verdict;
   end
endmodule : test_full_closed_position_feedback
`default_nettype wire
